// >>> fc_pkg.sv
// shared constants and types of the flow-control credit loop
package fc_pkg;

    // credit type of a packet or update; each has a header and a data counter
    typedef enum logic [1:0] {
        FC_POSTED     = 2'h0,
        FC_NONPOSTED  = 2'h1,
        FC_COMPLETION = 2'h2
    } fc_type_e;

    localparam int NUM_TYPES = 3;

    // counter widths fixed by the link protocol, wrapping modulo 2**width
    localparam int HDR_W  = 8;
    localparam int DATA_W = 12;

    // every packet takes one header credit
    localparam logic [HDR_W-1:0] HDR_PKT_CREDITS = 8'h01;

    // reset values of the credit counters
    localparam logic [HDR_W-1:0]  HDR_ZERO  = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;

    // receive buffer sizing defaults, large enough for several packets in flight
    localparam int RX_HDR_TOTAL_DEF  = 32;
    localparam int RX_DATA_TOTAL_DEF = 256;
    localparam int MAX_PAYLOAD_DEF   = 8;

    // a quarter of the buffer is total >> 2
    localparam int QUARTER_SHIFT = 2;

    // update resend timer
    localparam int CLOCK_PERIOD_NS       = 4;
    localparam int UPDATE_TIMEOUT_NS     = 30000;
    localparam int UPDATE_TIMEOUT_CYCLES = UPDATE_TIMEOUT_NS / CLOCK_PERIOD_NS;

    // update dllp sequencer, gray coded along idle, wait, send
    typedef enum logic [1:0] {
        UPD_IDLE = 2'h0,
        UPD_WAIT = 2'h1,
        UPD_SEND = 2'h3
    } upd_state_e;

endpackage : fc_pkg

// >>> fc_rx_if.sv
// bundle between the top and one receive credit counter
interface fc_rx_if #(
    parameter int W = 12
);
    logic         inc_valid;
    logic [W-1:0] inc_amt;
    logic         rcv_valid;
    logic [W-1:0] rcv_amt;
    logic         sent;
    logic [W-1:0] alloc;
    logic         pending;
    logic         urgent;

    modport counter (
        input  inc_valid, inc_amt, rcv_valid, rcv_amt, sent,
        output alloc, pending, urgent
    );
    modport owner (
        output inc_valid, inc_amt, rcv_valid, rcv_amt, sent,
        input  alloc, pending, urgent
    );
endinterface : fc_rx_if

// >>> fc_rx_counter.sv
// one receive credit-allocated counter with its urgency checks
module fc_rx_counter #(
    parameter int W       = 12,
    parameter int TOTAL   = 256,
    parameter int MAX_PAY = 8
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_nrst,
    // counter bundle
    fc_rx_if.counter  port
);
    localparam logic [W-1:0] TOTAL_C   = W'(TOTAL);
    localparam logic [W-1:0] QUARTER_C = W'(TOTAL >> fc_pkg::QUARTER_SHIFT);
    localparam logic [W-1:0] MAXPAY_C  = W'(MAX_PAY);

    logic [W-1:0] alloc_q;
    logic [W-1:0] last_q;
    logic [W-1:0] rcvd_q;
    logic [W-1:0] gained;
    logic [W-1:0] avail;
    logic         starve;
    logic         quarter;

    // starts at the whole buffer, grows as the application drains packets
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            alloc_q <= TOTAL_C;
        end else if (port.inc_valid) begin
            alloc_q <= W'(alloc_q + port.inc_amt);
        end
    end

    // value carried by the last update sent
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            last_q <= TOTAL_C;
        end else if (port.sent) begin
            last_q <= alloc_q;
        end
    end

    // credits received from the link so far
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rcvd_q <= '0;
        end else if (port.rcv_valid) begin
            rcvd_q <= W'(rcvd_q + port.rcv_amt);
        end
    end

    assign gained = W'(alloc_q - last_q);
    assign avail  = W'(last_q - rcvd_q);
    assign starve = (avail < MAXPAY_C) && (gained != '0);
    assign quarter = (gained >= QUARTER_C) && (gained != '0);

    assign port.alloc   = alloc_q;
    assign port.pending = (gained != '0);
    assign port.urgent  = starve || quarter;

    a_alloc_step: assert property (@(posedge i_clock) disable iff (!i_nrst)
        port.inc_valid |=> alloc_q == W'($past(alloc_q) + $past(port.inc_amt)))
        else $error("allocated counter did not grow by drained credits");

    a_last_sent: assert property (@(posedge i_clock) disable iff (!i_nrst)
        port.sent |=> last_q == $past(alloc_q))
        else $error("last sent value differs from the advertised counter");

    a_starve_urgent: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (W'(last_q - rcvd_q) < MAXPAY_C) && (alloc_q != last_q) |-> port.urgent)
        else $error("starving source did not raise update urgency");

    a_quarter_urgent: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (W'(alloc_q - last_q) >= QUARTER_C) && (alloc_q != last_q) |-> port.urgent)
        else $error("quarter buffer freed without update urgency");

endmodule : fc_rx_counter

// >>> flow_control_credit_loop.sv
// flow-control credit manager: transmit gating and receive update generation
// What this block does
// - The transmitter keeps a credit limit and a consumed count for each of six classes.
// - Credit limits load during flow-control init and later only from received updates.
// - A packet goes only when limit minus consumed covers its credits, otherwise it waits.
// - Header and data credits are checked separately and a packet takes one header credit.
// - A packet taken for sending bumps both header and data consumed counts.
// - The receiver keeps header and data allocated counters starting at the buffer size.
// - An allocated counter grows only after the application has read the whole packet.
// - Each update carries the current allocated counters of its type.
// - Update requests normally go at low priority behind packets and power-management messages.
// - An update turns urgent when the source is left with less than one max payload.
// - An update turns urgent when the resend timer since the last update expires.
// - An update turns urgent when a quarter of the buffer has been freed unadvertised.
// - A granted update waits for the packet on the link to finish, never preempting it.
// - A received update refreshes the limit and so releases stalled packets.
// - Buffer defaults leave room for several packets while the first update is in flight.
// - Urgent updates rank above power-management messages and packets, low ones below packets.
module flow_control_credit_loop #(
    parameter int TIMER_CYCLES  = fc_pkg::UPDATE_TIMEOUT_CYCLES,
    parameter int RX_HDR_TOTAL  = fc_pkg::RX_HDR_TOTAL_DEF,
    parameter int RX_DATA_TOTAL = fc_pkg::RX_DATA_TOTAL_DEF,
    parameter int MAX_PAYLOAD   = fc_pkg::MAX_PAYLOAD_DEF
) (
    // clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_nrst,
    // flow-control initialisation
    input  wire logic                      i_fc_init_phase,
    input  wire logic                      i_init_valid,
    input  wire logic [1:0]                i_init_type,
    input  wire logic [fc_pkg::HDR_W-1:0]  i_init_hdr,
    input  wire logic [fc_pkg::DATA_W-1:0] i_init_data,
    // received update dllp from the peer
    input  wire logic                      i_upd_valid,
    input  wire logic [1:0]                i_upd_type,
    input  wire logic [fc_pkg::HDR_W-1:0]  i_upd_hdr,
    input  wire logic [fc_pkg::DATA_W-1:0] i_upd_data,
    // application transmit request
    input  wire logic                      i_tx_valid,
    input  wire logic [1:0]                i_tx_type,
    input  wire logic [fc_pkg::DATA_W-1:0] i_tx_data_credits,
    output logic                           o_tx_ready,
    output logic                           o_tx_stalled,
    // power-management dllp request
    input  wire logic                      i_pm_req,
    output logic                           o_pm_grant,
    // link transmitter state
    input  wire logic                      i_link_busy,
    // packets arriving into the receive buffer
    input  wire logic                      i_rx_valid,
    input  wire logic [1:0]                i_rx_type,
    input  wire logic [fc_pkg::DATA_W-1:0] i_rx_data_credits,
    // application finished reading a whole packet
    input  wire logic                      i_drain_valid,
    input  wire logic [1:0]                i_drain_type,
    input  wire logic [fc_pkg::DATA_W-1:0] i_drain_data_credits,
    // outgoing update dllp
    output logic                           o_dllp_valid,
    output logic                           o_dllp_high,
    output fc_pkg::fc_type_e               o_dllp_type,
    output logic [fc_pkg::HDR_W-1:0]       o_dllp_hdr,
    output logic [fc_pkg::DATA_W-1:0]      o_dllp_data
);
    localparam int HW = fc_pkg::HDR_W;
    localparam int DW = fc_pkg::DATA_W;
    localparam int NT = fc_pkg::NUM_TYPES;
    localparam int TW = $clog2(TIMER_CYCLES + 1);
    localparam logic [TW-1:0] TIMER_LAST = TW'(TIMER_CYCLES - 1);

    // transmit side counters, one pair per type and width
    logic [HW-1:0] hdr_lim_q  [NT];
    logic [HW-1:0] hdr_cons_q [NT];
    logic [DW-1:0] dat_lim_q  [NT];
    logic [DW-1:0] dat_cons_q [NT];

    // receive side status gathered from the counters
    logic [HW-1:0] hdr_alloc [NT];
    logic [DW-1:0] dat_alloc [NT];
    logic [NT-1:0] pend;
    logic [NT-1:0] urg;
    logic [NT-1:0] hi;
    logic          any_hi;
    logic          any_pend;

    // update sequencer
    fc_pkg::upd_state_e st_q;
    logic [1:0]         sel_q;
    logic               sel_hi_q;
    logic [1:0]         pick;
    logic               send_now;

    // resend timer
    logic [TW-1:0] tmr_q;
    logic          tmr_exp_q;

    // transmit gating
    logic          tx_type_ok;
    logic [1:0]    tx_idx;
    logic [HW-1:0] hdr_room;
    logic [DW-1:0] dat_room;
    logic          credit_ok;
    logic          upd_block;
    logic          tx_take;

    // receive counters, header and data for every type
    for (genvar t = 0; t < NT; t++) begin : g_rx
        fc_rx_if #(.W(HW)) hdr_if ();
        fc_rx_if #(.W(DW)) dat_if ();

        assign hdr_if.inc_valid = i_drain_valid && (i_drain_type == 2'(t));
        assign hdr_if.inc_amt   = fc_pkg::HDR_PKT_CREDITS;
        assign hdr_if.rcv_valid = i_rx_valid && (i_rx_type == 2'(t));
        assign hdr_if.rcv_amt   = fc_pkg::HDR_PKT_CREDITS;
        assign hdr_if.sent      = send_now && (sel_q == 2'(t));
        assign dat_if.inc_valid = i_drain_valid && (i_drain_type == 2'(t));
        assign dat_if.inc_amt   = i_drain_data_credits;
        assign dat_if.rcv_valid = i_rx_valid && (i_rx_type == 2'(t));
        assign dat_if.rcv_amt   = i_rx_data_credits;
        assign dat_if.sent      = send_now && (sel_q == 2'(t));

        fc_rx_counter #(.W(HW), .TOTAL(RX_HDR_TOTAL), .MAX_PAY(1)) u_hdr (
            .i_clock (i_clock),
            .i_nrst  (i_nrst),
            .port    (hdr_if.counter)
        );
        fc_rx_counter #(.W(DW), .TOTAL(RX_DATA_TOTAL), .MAX_PAY(MAX_PAYLOAD)) u_dat (
            .i_clock (i_clock),
            .i_nrst  (i_nrst),
            .port    (dat_if.counter)
        );

        assign hdr_alloc[t] = hdr_if.alloc;
        assign dat_alloc[t] = dat_if.alloc;
        assign pend[t]      = hdr_if.pending || dat_if.pending;
        assign urg[t]       = hdr_if.urgent || dat_if.urgent;
        assign hi[t]        = pend[t] && (urg[t] || tmr_exp_q);
    end

    assign any_hi   = |hi;
    assign any_pend = |pend;

    // urgent types first, lowest type number wins a tie
    always_comb begin
        pick = '0;
        for (int t = NT - 1; t >= 0; t--) begin
            if (pend[t] && !any_hi) begin
                pick = 2'(t);
            end
            if (hi[t]) begin
                pick = 2'(t);
            end
        end
    end

    // credit limits: init phase loads, updates refresh afterwards
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int t = 0; t < NT; t++) begin
                hdr_lim_q[t] <= fc_pkg::HDR_ZERO;
                dat_lim_q[t] <= fc_pkg::DATA_ZERO;
            end
        end else if (i_fc_init_phase) begin
            if (i_init_valid && (i_init_type < 2'(NT))) begin
                hdr_lim_q[i_init_type] <= i_init_hdr;
                dat_lim_q[i_init_type] <= i_init_data;
            end
        end else if (i_upd_valid && (i_upd_type < 2'(NT))) begin
            hdr_lim_q[i_upd_type] <= i_upd_hdr;
            dat_lim_q[i_upd_type] <= i_upd_data;
        end
    end

    // sufficiency check on both header and data, modulo counter widths
    assign tx_type_ok = (i_tx_type < 2'(NT));
    assign tx_idx     = tx_type_ok ? i_tx_type : 2'h0;
    assign hdr_room   = HW'(hdr_lim_q[tx_idx] - hdr_cons_q[tx_idx]);
    assign dat_room   = DW'(dat_lim_q[tx_idx] - dat_cons_q[tx_idx]);
    assign credit_ok  = tx_type_ok && (hdr_room >= fc_pkg::HDR_PKT_CREDITS)
                        && (dat_room >= i_tx_data_credits);

    // an urgent or already granted update holds packets back
    assign upd_block  = any_hi || (st_q != fc_pkg::UPD_IDLE);
    assign o_tx_ready = !i_fc_init_phase && credit_ok && !i_link_busy
                        && !upd_block && !i_pm_req;
    assign o_pm_grant = i_pm_req && !i_link_busy && !upd_block;
    assign o_tx_stalled = i_tx_valid && !credit_ok;
    assign tx_take    = i_tx_valid && o_tx_ready;

    // consumed counts grow on every packet taken
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int t = 0; t < NT; t++) begin
                hdr_cons_q[t] <= fc_pkg::HDR_ZERO;
                dat_cons_q[t] <= fc_pkg::DATA_ZERO;
            end
        end else if (tx_take) begin
            hdr_cons_q[tx_idx] <= HW'(hdr_cons_q[tx_idx] + fc_pkg::HDR_PKT_CREDITS);
            dat_cons_q[tx_idx] <= DW'(dat_cons_q[tx_idx] + i_tx_data_credits);
        end
    end

    // update sequencer: grant, wait out the packet on the link, send
    assign send_now = (st_q == fc_pkg::UPD_WAIT) && !i_link_busy;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q     <= fc_pkg::UPD_IDLE;
            sel_q    <= '0;
            sel_hi_q <= 1'b0;
        end else begin
            case (st_q)
                fc_pkg::UPD_IDLE: begin
                    // low priority waits until no packet or pm message asks
                    if (!i_fc_init_phase && (any_hi
                        || (any_pend && !i_tx_valid && !i_pm_req))) begin
                        st_q     <= fc_pkg::UPD_WAIT;
                        sel_q    <= pick;
                        sel_hi_q <= any_hi;
                    end
                end
                fc_pkg::UPD_WAIT: begin
                    if (send_now) begin
                        st_q <= fc_pkg::UPD_SEND;
                    end
                end
                fc_pkg::UPD_SEND: begin
                    st_q <= fc_pkg::UPD_IDLE;
                end
                default: begin
                    st_q <= fc_pkg::UPD_IDLE;
                end
            endcase
        end
    end

    // update contents captured as the dllp leaves
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_dllp_type <= fc_pkg::FC_POSTED;
            o_dllp_hdr  <= fc_pkg::HDR_ZERO;
            o_dllp_data <= fc_pkg::DATA_ZERO;
            o_dllp_high <= 1'b0;
        end else if (send_now) begin
            o_dllp_type <= fc_pkg::fc_type_e'(sel_q);
            o_dllp_hdr  <= hdr_alloc[sel_q];
            o_dllp_data <= dat_alloc[sel_q];
            o_dllp_high <= sel_hi_q;
        end
    end

    assign o_dllp_valid = (st_q == fc_pkg::UPD_SEND);

    // resend timer restarts on every update sent
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tmr_q     <= '0;
            tmr_exp_q <= 1'b0;
        end else if (send_now) begin
            tmr_q     <= '0;
            tmr_exp_q <= 1'b0;
        end else if (tmr_q == TIMER_LAST) begin
            tmr_exp_q <= 1'b1;
        end else begin
            tmr_q <= TW'(tmr_q + 1'b1);
        end
    end

    a_credit_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
        tx_take |-> (HW'(hdr_lim_q[tx_idx] - hdr_cons_q[tx_idx]) != '0)
                    && (DW'(dat_lim_q[tx_idx] - dat_cons_q[tx_idx]) >= i_tx_data_credits))
        else $error("packet taken without sufficient credit");

    a_consume_step: assert property (@(posedge i_clock) disable iff (!i_nrst)
        tx_take && (tx_idx == 2'h0) |=> (hdr_cons_q[0] == HW'($past(hdr_cons_q[0]) + 1'b1))
            && (dat_cons_q[0] == DW'($past(dat_cons_q[0]) + $past(i_tx_data_credits))))
        else $error("consumed counts did not follow the packet taken");

    a_limit_held: assert property (@(posedge i_clock) disable iff (!i_nrst)
        !i_fc_init_phase && !i_upd_valid |=> $stable(dat_lim_q[0]) && $stable(hdr_lim_q[0]))
        else $error("credit limit changed without init or update");

    a_update_refresh: assert property (@(posedge i_clock) disable iff (!i_nrst)
        !i_fc_init_phase && i_upd_valid && (i_upd_type == 2'h1)
        |=> dat_lim_q[1] == $past(i_upd_data))
        else $error("received update did not refresh the limit");

    a_no_preempt: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (st_q == fc_pkg::UPD_WAIT) && i_link_busy |=> !o_dllp_valid)
        else $error("update sent while a packet was on the link");

    a_high_first: assert property (@(posedge i_clock) disable iff (!i_nrst)
        any_hi |-> !o_tx_ready && !o_pm_grant)
        else $error("urgent update lost arbitration");

    a_low_last: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (st_q == fc_pkg::UPD_IDLE) && !any_hi && i_tx_valid |=> st_q == fc_pkg::UPD_IDLE)
        else $error("low priority update overtook a packet");

    a_timer_raise: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (tmr_q == TIMER_LAST) && !send_now ##1 any_pend |-> any_hi)
        else $error("expired timer did not raise update priority");

    c_stall_release: cover property (@(posedge i_clock) disable iff (!i_nrst)
        o_tx_stalled ##1 i_upd_valid ##[1:8] tx_take);

    c_high_sent: cover property (@(posedge i_clock) disable iff (!i_nrst)
        o_dllp_valid && o_dllp_high);

    c_wait_busy: cover property (@(posedge i_clock) disable iff (!i_nrst)
        (st_q == fc_pkg::UPD_WAIT) && i_link_busy ##[1:60] o_dllp_valid);

endmodule : flow_control_credit_loop

// >>> fc_peer_model.sv
// model of the peer port that advertises credits to the block
module fc_peer_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    // command from the bench
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_init,
    input  wire logic [1:0]  i_cmd_type,
    input  wire logic [7:0]  i_cmd_hdr,
    input  wire logic [11:0] i_cmd_data,
    // credit advertisement towards the block
    output logic             o_init_valid,
    output logic             o_upd_valid,
    output logic [1:0]       o_type,
    output logic [7:0]       o_hdr,
    output logic [11:0]      o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_init_valid <= 1'b0;
            o_upd_valid  <= 1'b0;
        end else begin
            o_init_valid <= i_cmd_valid && i_cmd_init;
            // header and data limits of one type travel in one update
            o_upd_valid  <= i_cmd_valid && !i_cmd_init;
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_type <= 2'h0;
            o_hdr  <= 8'h00;
            o_data <= 12'h000;
        end else if (i_cmd_valid) begin
            o_type <= i_cmd_type;
            o_hdr  <= i_cmd_hdr;
            o_data <= i_cmd_data;
        end else begin
            // released fields never keep the last value
            o_type <= ~o_type;
            o_hdr  <= ~o_hdr;
            o_data <= ~o_data;
        end
    end
endmodule : fc_peer_model

// >>> tb_top.sv
// self-checking bench for the flow-control credit loop
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic fc_init = 1'b0, tx_v = 1'b0, pm = 1'b0, busy = 1'b0, rx_v = 1'b0, dr_v = 1'b0;
    logic [1:0] tx_t = 2'h0, rx_t = 2'h0, dr_t = 2'h0, c_t = 2'h0, p_t;
    logic [11:0] tx_d = 12'h000, rx_d = 12'h000, dr_d = 12'h000, c_d = 12'h000, p_d, r;
    logic [7:0] c_h = 8'h00, p_h, dhd;
    logic c_v = 1'b0, c_i = 1'b0, p_iv, p_uv, rdy, stl, pmg, dv, dh;
    logic [11:0] ddat;
    fc_pkg::fc_type_e dt;
    logic [22:0] exp_q[$];
    int err_count = 0, n_compared = 0, n_dllp = 0, cyc = 0, seed = 61486;

    always #2 i_clock = ~i_clock;

    fc_peer_model peer_m (.i_clock(i_clock), .i_nrst(i_nrst), .i_cmd_valid(c_v),
        .i_cmd_init(c_i), .i_cmd_type(c_t), .i_cmd_hdr(c_h), .i_cmd_data(c_d),
        .o_init_valid(p_iv), .o_upd_valid(p_uv), .o_type(p_t), .o_hdr(p_h), .o_data(p_d));

    flow_control_credit_loop #(.TIMER_CYCLES(20)) uut (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_fc_init_phase(fc_init), .i_init_valid(p_iv), .i_init_type(p_t),
        .i_init_hdr(p_h), .i_init_data(p_d), .i_upd_valid(p_uv), .i_upd_type(p_t),
        .i_upd_hdr(p_h), .i_upd_data(p_d), .i_tx_valid(tx_v), .i_tx_type(tx_t),
        .i_tx_data_credits(tx_d), .o_tx_ready(rdy), .o_tx_stalled(stl), .i_pm_req(pm),
        .o_pm_grant(pmg), .i_link_busy(busy), .i_rx_valid(rx_v), .i_rx_type(rx_t),
        .i_rx_data_credits(rx_d), .i_drain_valid(dr_v), .i_drain_type(dr_t),
        .i_drain_data_credits(dr_d), .o_dllp_valid(dv), .o_dllp_high(dh),
        .o_dllp_type(dt), .o_dllp_hdr(dhd), .o_dllp_data(ddat));

    task automatic check(input logic [22:0] seen, input logic [22:0] expv);
        n_compared++;
        if (seen !== expv) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // offer a packet for one cycle; it is taken when ready
    task automatic chk_tx(input logic [1:0] t, input logic [11:0] d, input logic e, input logic s);
        @(posedge i_clock);
        tx_v <= 1'b1;
        tx_t <= t;
        tx_d <= d;
        @(negedge i_clock);
        check({21'h0, rdy, stl}, {21'h0, e, s});
        @(posedge i_clock);
        tx_v <= 1'b0;
    endtask : chk_tx

    task automatic peer(input logic i, input logic [1:0] t, input logic [7:0] h, input logic [11:0] d);
        @(posedge i_clock);
        c_v <= 1'b1;
        c_i <= i;
        c_t <= t;
        c_h <= h;
        c_d <= d;
        @(posedge i_clock);
        c_v <= 1'b0;
        repeat (2) @(posedge i_clock);
    endtask : peer

    // arrival into, or full read-out from, the receive buffer
    task automatic pkt(input logic drain, input logic [1:0] t, input logic [11:0] d);
        @(posedge i_clock);
        if (drain) begin
            dr_v <= 1'b1;
            dr_t <= t;
            dr_d <= d;
        end else begin
            rx_v <= 1'b1;
            rx_t <= t;
            rx_d <= d;
        end
        @(posedge i_clock);
        dr_v <= 1'b0;
        rx_v <= 1'b0;
    endtask : pkt

    task automatic wait_dllp(input int n, input int lim);
        int k;
        k = 0;
        while (n_dllp < n && k < lim) begin
            @(posedge i_clock);
            k++;
        end
        check({22'h0, n_dllp == n}, 23'h1);
    endtask : wait_dllp

    always @(posedge i_clock) begin
        if (dv === 1'b1) begin
            n_dllp++;
            if (exp_q.size() == 0)
                check(23'h1, 23'h0);
            else
                check({dh, dt, dhd, ddat}, exp_q.pop_front());
        end
    end

    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        fc_init <= 1'b1;
        peer(1'b1, 2'h0, 8'h02, 12'h010);
        peer(1'b1, 2'h1, 8'h01, 12'h000);
        peer(1'b1, 2'h2, 8'h02, 12'hFA0);
        peer(1'b0, 2'h0, 8'h64, 12'h3E8);
        @(posedge i_clock);
        fc_init <= 1'b0;
        chk_tx(2'h0, 12'h011, 1'b0, 1'b1);
        chk_tx(2'h0, 12'h010, 1'b1, 1'b0);
        chk_tx(2'h0, 12'h000, 1'b1, 1'b0);
        chk_tx(2'h0, 12'h000, 1'b0, 1'b1);
        chk_tx(2'h1, 12'h001, 1'b0, 1'b1);
        chk_tx(2'h1, 12'h000, 1'b1, 1'b0);
        chk_tx(2'h3, 12'h000, 1'b0, 1'b1);
        $display("test tx_gating done");
        peer(1'b0, 2'h0, 8'h04, 12'h028);
        chk_tx(2'h0, 12'h019, 1'b0, 1'b1);
        chk_tx(2'h0, 12'h018, 1'b1, 1'b0);
        chk_tx(2'h2, 12'hFA0, 1'b1, 1'b0);
        peer(1'b0, 2'h2, 8'h02, 12'h068);
        chk_tx(2'h2, 12'h0C9, 1'b0, 1'b1);
        pm <= 1'b1;
        chk_tx(2'h2, 12'h0C8, 1'b0, 1'b0);
        @(negedge i_clock);
        check({22'h0, pmg}, 23'h1);
        @(posedge i_clock);
        pm <= 1'b0;
        chk_tx(2'h2, 12'h0C8, 1'b1, 1'b0);
        $display("test update_release done");
        pkt(1'b0, 2'h0, 12'h005);
        repeat (10) @(posedge i_clock);
        wait_dllp(0, 0);
        r = 12'($random(seed) & 32'hF) + 12'h001;
        // the resend timer has long run out since reset, so the first update goes urgent
        exp_q.push_back({1'b1, 2'h0, 8'h21, 12'h100 + r});
        pkt(1'b1, 2'h0, r);
        wait_dllp(1, 30);
        tx_t <= 2'h3;
        tx_v <= 1'b1;
        exp_q.push_back({1'b1, 2'h1, 8'h21, 12'h140});
        pkt(1'b1, 2'h1, 12'h040);
        wait_dllp(2, 12);
        pkt(1'b0, 2'h2, 12'h0FA);
        exp_q.push_back({1'b1, 2'h2, 8'h21, 12'h101});
        pkt(1'b1, 2'h2, 12'h001);
        wait_dllp(3, 12);
        busy <= 1'b1;
        exp_q.push_back({1'b1, 2'h0, 8'h22, 12'h101 + r});
        pkt(1'b1, 2'h0, 12'h001);
        pm <= 1'b1;
        repeat (40) @(posedge i_clock);
        wait_dllp(3, 0);
        @(negedge i_clock);
        check({22'h0, pmg}, 23'h0);
        @(posedge i_clock);
        busy <= 1'b0;
        pm <= 1'b0;
        wait_dllp(4, 12);
        tx_v <= 1'b0;
        // fresh timer, no packet waiting: this update leaves at low priority
        exp_q.push_back({1'b0, 2'h1, 8'h22, 12'h141});
        pkt(1'b1, 2'h1, 12'h001);
        wait_dllp(5, 12);
        check({22'h0, exp_q.size() == 0}, 23'h1);
        $display("test update_priority done");
        final_report();
    end
endmodule : tb_top
